/* File: test/pld_src_model.sv */
// Upstream demultiplexer model that hands descriptor bytes to the parser
module pld_src_model (
    input wire logic ref_clk, // Clock
    input wire logic inReady, // Parser can take a byte
    input wire logic clkEn, // Parser enable; nothing is taken while low
    output logic [7:0] inByte, // Descriptor byte
    output logic inValid // Byte present
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] txQ[$];
    logic [7:0] lastB = 8'h00;
    int gap = 0; // Idle cycles after each byte, for slow sending
    int waitN = 0;
    initial inByte = 8'h00;
    initial inValid = 1'b0;
    // A byte stands until taken; idle lines show the inverse of the last one
    always @(posedge ref_clk) begin
        if (inValid && inReady && clkEn) begin
            lastB = txQ.pop_front();
            waitN = gap;
        end
        if (!inValid || (inReady && clkEn)) begin
            if (waitN > 0 || txQ.size() == 0) begin
                waitN = (waitN > 0) ? waitN - 1 : 0;
                inValid <= 1'b0;
                inByte <= ~lastB;
            end else begin
                inValid <= 1'b1;
                inByte <= txQ[0];
            end
        end
    end
endmodule : pld_src_model

/* File: test/testbench.sv */
// Self-checking bench for the descriptor parser
module testbench
    import pld_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, reset, clkEn, inValid, inReady, policyUpdate, outSep, outLast, outValid;
    logic outReady = 1'b0;
    logic hold = 1'b0;
    logic [1:0] cyc = 2'h0;
    logic [7:0] inByte, outByte, pl;
    logic [1:0] outKind;
    logic [11:0] policyDenied, pe;
    logic [23:0] pp;
    logic [10:0] rxQ[$];
    logic sawFull = 1'b0;
    int updCnt = 0;
    int u0, error_cnt = 0, n_tests = 0;
    // Policy cases: length, payload bytes, expected flags
    logic [43:0] polRows [6] = '{{8'h01, 24'h800000, 12'hFFF},
        {8'h02, 24'h40F000, 12'hF02},
        {8'h01, 24'h550000, 12'h0AA},
        {8'h00, 24'h000000, 12'h000},
        {8'h03, 24'h500FFF, 12'h00A},
        {8'h02, 24'h208000, 12'h104}};
    logic [10:0] txtExp [6] = '{{KIND_LABEL, 1'b0, 8'h61}, {KIND_LABEL, 1'b1, 8'h3B},
        {KIND_LABEL, 1'b0, 8'h62}, {KIND_LOCATOR, 1'b0, 8'h78},
        {KIND_LOCATOR, 1'b0, 8'h3B}, {KIND_LOCATOR, 1'b0, 8'h79}};

    pld_parser DUT (.ref_clk(ref_clk), .reset(reset), .clkEn(clkEn), .inByte(inByte),
        .inValid(inValid), .inReady(inReady), .policyDenied(policyDenied),
        .policyUpdate(policyUpdate), .outByte(outByte), .outKind(outKind), .outSep(outSep),
        .outLast(outLast), .outValid(outValid), .outReady(outReady));
    pld_src_model src (.ref_clk(ref_clk), .inReady(inReady), .clkEn(clkEn), .inByte(inByte),
        .inValid(inValid));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Drain stalls every fourth cycle so the output holds under back-pressure
    always @(posedge ref_clk) begin
        cyc <= cyc + 2'h1;
        outReady <= !hold && (cyc != 2'h3);
    end
    // Monitor of accepted output bytes, flag reloads and refusals
    always @(posedge ref_clk) begin
        if (outValid && outReady && clkEn) rxQ.push_back({outKind, outSep, outByte});
        if (policyUpdate && clkEn) updCnt++;
        if (inValid && !inReady) sawFull = 1'b1;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic send(input logic [7:0] tag, input logic [7:0] len, input logic [23:0] pay,
        input int n);
        @(negedge ref_clk);
        src.txQ.push_back(tag);
        src.txQ.push_back(len);
        for (int k = 0; k < n; k++) src.txQ.push_back(pay[23-8*k -: 8]);
    endtask : send
    // Bounded wait until the source is empty and the output side has drained
    task automatic settle();
        for (int t = 0; t < 300 && (src.txQ.size() > 0 || src.inValid || outValid); t++)
            @(negedge ref_clk);
        repeat (3) @(negedge ref_clk);
    endtask : settle
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        #200000;
        error_cnt++;
        summarize();
    end
    initial begin
        reset = 1'b1;
        clkEn = 1'b1;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        @(negedge ref_clk);
        chk(16'(policyDenied), 16'h0000);
        chk(16'(inReady), 16'h0001);
        $display("test reset done");
        foreach (polRows[i]) begin
            {pl, pp, pe} = polRows[i];
            src.gap = i % 2;
            u0 = updCnt;
            send(TAG_POLICY, pl, pp, int'(pl));
            settle();
            chk(16'(updCnt - u0), 16'h0001);
            chk(16'(policyDenied), 16'(pe));
            $display("test policy row %0d done", i);
        end
        // Unknown tag whose payload mimics a policy header must be skipped
        u0 = updCnt;
        send(8'h7E, 8'h02, 24'hAF0100, 2);
        send(TAG_LABEL, 8'h03, 24'h613B62, 3);
        send(TAG_LOCATOR, 8'h03, 24'h783B79, 3);
        settle();
        chk(16'(updCnt - u0), 16'h0000);
        chk(16'(policyDenied), 16'h0104);
        chk(16'(rxQ.size()), 16'h0006);
        foreach (txtExp[i]) chk(16'(rxQ[i]), 16'(txtExp[i]));
        $display("test text done");
        rxQ.delete();
        // Long label against a stalled drain fills the buffer until it refuses
        hold = 1'b1;
        sawFull = 1'b0;
        send(TAG_LABEL, 8'h18, 24'h000000, 0);
        for (int k = 0; k < 24; k++) src.txQ.push_back(8'h41 + 8'(k));
        repeat (60) @(negedge ref_clk);
        chk(16'(sawFull), 16'h0001);
        chk(16'(rxQ.size()), 16'h0000);
        hold = 1'b0;
        settle();
        chk(16'(rxQ.size()), 16'h0018);
        foreach (rxQ[k]) chk(16'(rxQ[k]), {5'h00, KIND_LABEL, 1'b0, 8'h41 + 8'(k)});
        $display("test buffer done");
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        @(negedge ref_clk);
        chk(16'(policyDenied), 16'h0000);
        chk(16'(outLast), 16'h0000);
        $display("test mid reset done");
        // Frozen enable: the byte on offer waits, flags and pulse stay put
        u0 = updCnt;
        @(posedge ref_clk);
        clkEn <= 1'b0;
        send(TAG_POLICY, 8'h01, 24'h400000, 1);
        repeat (10) @(negedge ref_clk);
        chk(16'(src.txQ.size()), 16'h0003);
        chk(16'(updCnt - u0), 16'h0000);
        @(posedge ref_clk);
        clkEn <= 1'b1;
        settle();
        chk(16'(updCnt - u0), 16'h0001);
        chk(16'(policyDenied), 16'h0002);
        $display("test clock enable done");
        summarize();
    end
endmodule : testbench

/* File: verilog/pld_fifo.sv */
// Parameterised flip-flop FIFO with valid and ready on both sides
module pld_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk, // Clock
    input wire logic reset, // Async reset, active high
    input wire logic clkEn, // Clock enable
    input wire logic [WIDTH-1:0] inData, // Write data
    input wire logic inValid, // Write request
    output logic inReady, // Not full
    output logic [WIDTH-1:0] outData, // Head word
    output logic outValid, // Not empty
    input wire logic outReady // Drain accepts
);
    localparam int AW = $clog2(DEPTH);
    // Wrap-bit pointers only work for a power-of-two depth; refuse the rest at elaboration
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_badParam
        $error("pld_fifo: DEPTH must be a power of two, at least 2, WIDTH at least 1");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr_reg;
    logic [AW:0] rdPtr_reg;
    wire doWrite = clkEn && inValid && inReady;
    wire doRead = clkEn && outValid && outReady;

    // Full when pointers differ only in wrap bit
    assign inReady = (wrPtr_reg != {~rdPtr_reg[AW], rdPtr_reg[AW-1:0]});
    assign outValid = (wrPtr_reg != rdPtr_reg);
    assign outData = mem[rdPtr_reg[AW-1:0]];

    // Storage has no reset; pointers decide what is valid
    always_ff @(posedge ref_clk) begin
        if (doWrite) begin
            mem[wrPtr_reg[AW-1:0]] <= inData;
        end
    end

    // Pointer update
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
        end else begin
            if (doWrite) wrPtr_reg <= wrPtr_reg + 1'b1;
            if (doRead) rdPtr_reg <= rdPtr_reg + 1'b1;
        end
    end
endmodule : pld_fifo

/* File: verilog/pld_parser.sv */
// Byte-serial parser for policy, service label and locator descriptors
// Contract
// - Policy descriptor has tag AF, then an 8-bit payload byte count.
// - Payload bytes concatenate; MSB of first byte is vector bit zero.
// - A vector bit of one means that policy is denied.
// - Bits not carried because of shortening read as zero.
// - Bits 0..11 map to all, RF, virtual, exec, ext, overlay, ... prefs.
// - Bit zero set reports every individual policy as denied.
// - Service label descriptor has tag B0, length counts label bytes.
// - Semicolon in a label separates service names and is flagged.
// - Locator descriptor has tag B1, length counts locator bytes.
// - Read exactly length payload bytes, then expect the next tag.
module pld_parser
    import pld_pkg::*;
(
    input wire logic ref_clk, // Clock, 100 MHz
    input wire logic reset, // Async reset, active high
    input wire logic clkEn, // Freezes all state when low
    input wire logic [7:0] inByte, // Descriptor byte from demultiplexer
    input wire logic inValid, // Byte present
    output logic inReady, // Parser can take a byte
    output logic [POLICY_BITS-1:0] policyDenied, // Per-policy denial flags
    output logic policyUpdate, // Pulse when flags reloaded
    output logic [7:0] outByte, // Label or locator byte
    output logic [1:0] outKind, // 1 label, 2 locator
    output logic outSep, // Byte is a name separator
    output logic outLast, // Reserved, always low
    output logic outValid, // Output byte present
    input wire logic outReady // Downstream accepts
);
    pld_state_t state_reg;
    logic [7:0] tag_reg;
    logic [7:0] remain_reg;
    logic [7:0] byteIdx_reg;
    logic [POLICY_BITS-1:0] collect_reg;
    logic [POLICY_BITS-1:0] policy_reg;
    logic update_reg;
    logic [FIFO_WIDTH-1:0] headWord_reg;
    logic headValid_reg;
    logic headLast_reg;

    // FIFO wires
    logic fifoInReady;
    logic [FIFO_WIDTH-1:0] fifoOutData;
    logic fifoOutValid;
    logic fifoPush;
    pld_out_t pushWord;

    // Decode of the current byte
    wire take = clkEn && inValid && inReady;
    wire isPolicy = (tag_reg == TAG_POLICY);
    wire isLabel = (tag_reg == TAG_LABEL);
    wire isLocator = (tag_reg == TAG_LOCATOR);
    wire isText = isLabel || isLocator;
    wire lastBody = (remain_reg == 8'h01);
    // Stall input only when a text byte must be pushed into a full FIFO
    assign inReady = !(state_reg == ST_BODY && isText && !fifoInReady);
    assign fifoPush = take && state_reg == ST_BODY && isText;
    assign pushWord = '{kind: (isLabel ? KIND_LABEL : KIND_LOCATOR),
                        sep: isLabel && (inByte == CHAR_SEPARATOR),
                        data: inByte};

    // Merge a policy byte into the vector; bit i sits at byte i/8, bit 7-i%8
    logic [POLICY_BITS-1:0] mergedBits;
    genvar gi;
    generate
        for (gi = 0; gi < POLICY_BITS; gi++) begin : g_bit
            // bits above 11 never land anywhere
            assign mergedBits[gi] = (byteIdx_reg == 8'(gi / 8)) ?
                inByte[7 - (gi % 8)] : collect_reg[gi];
        end
    endgenerate

    // Bit zero overrides every policy
    wire [POLICY_BITS-1:0] finalBits =
        mergedBits[BIT_ALL] ? {POLICY_BITS{1'b1}} : mergedBits;

    // Descriptor walk
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_reg <= ST_TAG;
            tag_reg <= 8'h00;
            remain_reg <= 8'h00;
            byteIdx_reg <= 8'h00;
            collect_reg <= POLICY_RESET;
        end else if (take) begin
            case (state_reg)
                ST_TAG: begin
                    tag_reg <= inByte;
                    state_reg <= ST_LEN;
                end
                ST_LEN: begin
                    remain_reg <= inByte;
                    byteIdx_reg <= 8'h00;
                    collect_reg <= POLICY_RESET; // uncarried bits stay zero
                    state_reg <= (inByte == 8'h00) ? ST_TAG : ST_BODY;
                end
                ST_BODY: begin
                    remain_reg <= remain_reg - 8'h01;
                    byteIdx_reg <= byteIdx_reg + 8'h01;
                    collect_reg <= mergedBits;
                    if (lastBody) state_reg <= ST_TAG;
                end
                default: state_reg <= ST_TAG;
            endcase
        end
    end

    // Policy flags load only when a whole policy descriptor has arrived
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            policy_reg <= POLICY_RESET;
            update_reg <= 1'b0;
        end else if (clkEn) begin
            update_reg <= 1'b0;
            if (take && isPolicy && state_reg == ST_BODY && lastBody) begin
                policy_reg <= finalBits;
                update_reg <= 1'b1;
            end else if (take && state_reg == ST_LEN && inByte == 8'h00 &&
                         tag_reg == TAG_POLICY) begin
                policy_reg <= POLICY_RESET; // empty payload, nothing denied
                update_reg <= 1'b1;
            end
        end
    end

    pld_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .reset(reset),
        .clkEn(clkEn),
        .inData(pushWord),
        .inValid(fifoPush),
        .inReady(fifoInReady),
        .outData(fifoOutData),
        .outValid(fifoOutValid),
        .outReady(!headValid_reg || outReady)
    );

    // Output register stage so outputs come from flops
    wire headLoad = fifoOutValid && (!headValid_reg || outReady);
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            headWord_reg <= '0;
            headValid_reg <= 1'b0;
            headLast_reg <= 1'b0;
        end else if (clkEn) begin
            if (headLoad) begin
                headWord_reg <= fifoOutData;
                headValid_reg <= 1'b1;
                headLast_reg <= 1'b0;
            end else if (outReady) begin
                headValid_reg <= 1'b0;
            end
        end
    end

    pld_out_t headView;
    assign headView = headWord_reg;
    assign outByte = headView.data;
    assign outKind = headView.kind;
    assign outSep = headView.sep;
    assign outLast = headLast_reg;
    assign outValid = headValid_reg;
    assign policyDenied = policy_reg;
    assign policyUpdate = update_reg;

    // Checks
    property p_hold;
        @(posedge ref_clk) disable iff (reset)
        !update_reg |-> (policy_reg == $past(policy_reg));
    endproperty
    a_hold: assert property (p_hold) else $error("policy flags moved");

    property p_all;
        @(posedge ref_clk) disable iff (reset)
        policy_reg[BIT_ALL] |-> (&policy_reg);
    endproperty
    a_all: assert property (p_all) else $error("all bit not expanded");

    // Checked where the byte leaves, so the mark must survive the FIFO and head stage
    property p_sep;
        @(posedge ref_clk) disable iff (reset)
        headValid_reg |-> (headView.sep == (headView.kind == KIND_LABEL &&
                                            headView.data == CHAR_SEPARATOR));
    endproperty
    a_sep: assert property (p_sep) else $error("bad separator mark");

    // Final payload byte accepted
    sequence s_lastBody;
        take && state_reg == ST_BODY && lastBody;
    endsequence

    property p_end;
        @(posedge ref_clk) disable iff (reset)
        s_lastBody |=> (state_reg == ST_TAG);
    endproperty
    a_end: assert property (p_end) else $error("length not honoured");

    property p_count;
        @(posedge ref_clk) disable iff (reset)
        (take && state_reg == ST_BODY) |=> (remain_reg == $past(remain_reg) - 8'h01);
    endproperty
    a_count: assert property (p_count) else $error("count slip");

    property p_msb;
        @(posedge ref_clk) disable iff (reset)
        (take && isPolicy && state_reg == ST_BODY && byteIdx_reg == 8'h00 && lastBody)
        |=> (policy_reg[1] == $past(inByte[6]) || policy_reg[BIT_ALL]);
    endproperty
    a_msb: assert property (p_msb) else $error("bit order wrong");

    property p_short;
        @(posedge ref_clk) disable iff (reset)
        (take && isPolicy && state_reg == ST_BODY && byteIdx_reg == 8'h00 && lastBody
         && !inByte[7]) |=> (policy_reg[11:8] == 4'h0);
    endproperty
    a_short: assert property (p_short) else $error("short payload bits set");

    property p_kind;
        @(posedge ref_clk) disable iff (reset)
        (take && state_reg == ST_BODY && isLocator) |->
            (fifoPush && pushWord.kind == KIND_LOCATOR && !pushWord.sep &&
             pushWord.data == inByte);
    endproperty
    a_kind: assert property (p_kind) else $error("kind wrong");
endmodule : pld_parser

/* File: verilog/pld_pkg.sv */
// Package for the policy, label and locator descriptor parser
package pld_pkg;
    localparam logic [7:0] TAG_POLICY = 8'hAF;
    localparam logic [7:0] TAG_LABEL = 8'hB0;
    localparam logic [7:0] TAG_LOCATOR = 8'hB1;
    localparam logic [7:0] CHAR_SEPARATOR = 8'h3B;
    localparam int POLICY_BITS = 12;
    localparam int POLICY_BYTES = 2;
    localparam int BIT_ALL = 0;
    localparam logic [POLICY_BITS-1:0] POLICY_RESET = 12'h000;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_WIDTH = 11;
    localparam logic [1:0] KIND_LABEL = 2'h1;
    localparam logic [1:0] KIND_LOCATOR = 2'h2;

    // One output byte with its marks
    typedef struct packed {
        logic [1:0] kind;
        logic sep;
        logic [7:0] data;
    } pld_out_t;

    typedef enum logic [1:0] {ST_TAG, ST_LEN, ST_BODY} pld_state_t;
endpackage : pld_pkg
